//--- core/pwl_top.v
// pwl_top.v: pulse width measurement and periodic logging strobe fabric
// assumes all inputs synchronous to sys_clk at 10 MHz; config bits are pins
//
// Behaviour
// - run event starts counting per selected tick
// - capture event copies count to holding register
// - stop with preset enabled halts and presets
// - high time: rise starts, fall stops and captures
// - linear mode spans full 32-bit unsigned range
// - low time: edge selections swap
// - ring mode wraps to lower as count reaches upper limit
// - compare match strobes output one clock
// - each strobe increments second counter
// - second counter reaching 1000 stops first
// - stop presets first counter to 0, idle
// - capture stored at assigned buffer address
// - strobe every 20 us, stop after 1000
`include "pwl_defs.vh"
module pwl_top #(
  parameter CLK_NS     = `PWL_CLK_NS,
  parameter FAST_NS    = `PWL_TICK_FAST_NS,
  parameter SLOW_NS    = `PWL_TICK_SLOW_NS,
  parameter LOG_POINTS = `PWL_LOG_POINTS,
  parameter CAP_ADDR   = `PWL_CAP_ADDR
) (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        clk_en,
  // pulse measurement channel
  input  wire        meas_in,
  input  wire        meas_enable,
  input  wire        meas_low_time,
  input  wire        meas_ring_mode,
  // logging channel
  input  wire        log_start_in,
  input  wire        log_enable,
  // software read port of captured width
  input  wire [15:0] buf_addr,
  output reg  [31:0] buf_rdata,
  output wire [31:0] meas_count,
  output wire [31:0] meas_capture,
  output wire        meas_capture_valid,
  output wire        meas_running,
  output wire        log_strobe,
  output wire        log_running,
  output wire [31:0] log_points,
  output reg         log_done
);
  // tick periods in sys_clk cycles, never below one
  localparam FAST_RAW  = SLOW_NS / CLK_NS;
  localparam SLOW_CYC  = (FAST_RAW < 1) ? 1 : FAST_RAW;
  localparam FAST_CYC0 = FAST_NS / CLK_NS;
  // the 25 ns tick is faster than sys_clk: count every clock instead
  localparam FAST_CYC  = (FAST_CYC0 < 1) ? 1 : FAST_CYC0;
  localparam TW        = 16;
  localparam integer  SLOW_M1   = SLOW_CYC - 1;
  localparam integer  FAST_M1   = FAST_CYC - 1;
  // cut to the divider width on purpose
  localparam [TW-1:0] SLOW_LAST = SLOW_M1[TW-1:0];
  localparam [TW-1:0] FAST_LAST = FAST_M1[TW-1:0];

  reg  [TW-1:0] slow_div_reg;
  reg  [TW-1:0] fast_div_reg;
  reg           meas_prev_reg;
  reg           start_prev_reg;
  wire          slow_tick = (slow_div_reg == SLOW_LAST);
  wire          fast_tick = (fast_div_reg == FAST_LAST);

  // tick dividers and input edge history
  always @(posedge sys_clk) begin
    if (!nrst) begin
      slow_div_reg   <= {TW{1'b0}};
      fast_div_reg   <= {TW{1'b0}};
      meas_prev_reg  <= 1'b0;
      start_prev_reg <= 1'b0;
    end else if (clk_en) begin
      slow_div_reg   <= slow_tick ? {TW{1'b0}} : slow_div_reg + 16'h0001;
      fast_div_reg   <= fast_tick ? {TW{1'b0}} : fast_div_reg + 16'h0001;
      meas_prev_reg  <= meas_in;
      start_prev_reg <= log_start_in;
    end
  end

  // edge detectors; low-time swaps the selections
  wire meas_rise = meas_in & ~meas_prev_reg;
  wire meas_fall = ~meas_in & meas_prev_reg;
  wire m_run  = meas_low_time ? meas_fall : meas_rise;
  wire m_stop = meas_low_time ? meas_rise : meas_fall;
  wire log_start = log_start_in & ~start_prev_reg;

  // pulse width counter: linear or ring per meas_ring_mode, full range, preset 0 on stop
  pwl_counter #(.W(32)) u_meas (
    .sys_clk          (sys_clk),
    .nrst             (nrst),
    .clk_en           (clk_en),
    .tick             (fast_tick),
    .count_enable     (meas_enable),
    .ring_mode        (meas_ring_mode),
    .stop_preset_en   (1'b1),
    .upper_limit      (`PWL_LIN_UPPER),
    .lower_limit      (`PWL_LIN_LOWER),
    .preset_value     (`PWL_PRESET_ZERO),
    .compare_a        (`PWL_LIN_UPPER),
    .run_evt          (m_run),
    .stop_evt         (m_stop),
    .capture_evt      (m_stop),
    .count_reg        (meas_count),
    .capture_reg      (meas_capture),
    .capture_valid_reg(meas_capture_valid),
    .running_reg      (meas_running),
    .match_reg        ()
  );

  wire        log_stop;
  wire [31:0] ring_count;
  wire        ring_match;
  wire        pts_match;

  // ring counter 1..20 at 1 us, wraps as it reaches 21, strobe on 1
  pwl_counter #(.W(32)) u_ring (
    .sys_clk          (sys_clk),
    .nrst             (nrst),
    .clk_en           (clk_en),
    .tick             (slow_tick),
    .count_enable     (log_enable),
    .ring_mode        (1'b1),
    .stop_preset_en   (1'b1),
    .upper_limit      (`PWL_RING_UPPER),
    .lower_limit      (`PWL_RING_LOWER),
    .preset_value     (`PWL_PRESET_ZERO),
    .compare_a        (`PWL_STROBE_CMP),
    .run_evt          (log_start),
    .stop_evt         (log_stop),
    .capture_evt      (1'b0),
    .count_reg        (ring_count),
    .capture_reg      (),
    .capture_valid_reg(),
    .running_reg      (log_running),
    .match_reg        (ring_match)
  );

  assign log_strobe = ring_match;

  // point counter: cleared by a start edge, then runs while the ring runs;
  // a restart while running lets the clear win that clock
  pwl_counter #(.W(32)) u_pts (
    .sys_clk          (sys_clk),
    .nrst             (nrst),
    .clk_en           (clk_en),
    .tick             (ring_match),
    .count_enable     (log_enable),
    .ring_mode        (1'b0),
    .stop_preset_en   (1'b1),
    .upper_limit      (`PWL_LIN_UPPER),
    .lower_limit      (`PWL_LIN_LOWER),
    .preset_value     (`PWL_PRESET_ZERO),
    .compare_a        (LOG_POINTS),
    .run_evt          (log_running),
    .stop_evt         (log_start),
    .capture_evt      (1'b0),
    .count_reg        (log_points),
    .capture_reg      (),
    .capture_valid_reg(),
    .running_reg      (),
    .match_reg        (pts_match)
  );

  // 1000th point stops the ring the very next clock
  assign log_stop = pts_match;

  // done flag: set on last point, cleared by next start
  always @(posedge sys_clk) begin
    if (!nrst)
      log_done <= 1'b0;
    else if (clk_en && log_enable) begin
      if (pts_match)
        log_done <= 1'b1;
      else if (log_start)
        log_done <= 1'b0;
    end
  end

  // buffer memory read: captured width at its assigned word
  always @(posedge sys_clk) begin
    if (!nrst)
      buf_rdata <= 32'h00000000;
    else if (clk_en)
      buf_rdata <= (buf_addr == CAP_ADDR) ? meas_capture
                                          : 32'h00000000;
  end
endmodule // pwl_top

//--- inc/pwl_defs.vh
// pwl_defs.vh: constants shared by the pulse width / logging counter
// assumes a 10 MHz system clock (100 ns period)
`ifndef PWL_DEFS_VH
`define PWL_DEFS_VH

// clock rate and tick periods, in ns
`define PWL_CLK_NS        100
`define PWL_TICK_FAST_NS  25
`define PWL_TICK_SLOW_NS  1000

// counter limits and presets
`define PWL_CNT_W         32
`define PWL_LIN_UPPER     32'hffffffff
`define PWL_LIN_LOWER     32'h00000000
`define PWL_RING_UPPER    32'h00000015
`define PWL_RING_LOWER    32'h00000001
`define PWL_PRESET_ZERO   32'h00000000
`define PWL_STROBE_CMP    32'h00000001
`define PWL_LOG_POINTS    32'h000003e8
`define PWL_CAP_ADDR      16'h03e8

// edge select encodings
`define PWL_EDGE_RISE     1'b0
`define PWL_EDGE_FALL     1'b1

// count mode encodings
`define PWL_MODE_LINEAR   1'b0
`define PWL_MODE_RING     1'b1

`endif

//--- core/pwl_counter.v
// pwl_counter.v: one counter/timer block with run/stop/preset and compare
// assumes run/stop/capture are one-cycle events in the sys_clk domain
`include "pwl_defs.vh"
module pwl_counter #(
  parameter W = `PWL_CNT_W
) (
  input  wire         sys_clk,
  input  wire         nrst,
  input  wire         clk_en,
  input  wire         tick,
  input  wire         count_enable,
  input  wire         ring_mode,
  input  wire         stop_preset_en,
  input  wire [W-1:0] upper_limit,
  input  wire [W-1:0] lower_limit,
  input  wire [W-1:0] preset_value,
  input  wire [W-1:0] compare_a,
  input  wire         run_evt,
  input  wire         stop_evt,
  input  wire         capture_evt,
  output reg  [W-1:0] count_reg,
  output reg  [W-1:0] capture_reg,
  output reg          capture_valid_reg,
  output reg          running_reg,
  output reg          match_reg
);
  reg [W-1:0] count_next;
  reg         running_next;
  wire        active = clk_en & count_enable;
  wire [W-1:0] count_inc = count_reg + {{(W-1){1'b0}}, 1'b1};

  // next count: stop beats run, wrap in ring mode
  always @* begin
    count_next   = count_reg;
    running_next = running_reg;
    if (stop_evt) begin
      running_next = 1'b0;
      if (stop_preset_en)
        count_next = preset_value;
    end else begin
      if (run_evt)
        running_next = 1'b1;
      if (running_reg && tick) begin
        // ring wraps as the count reaches the upper limit, so the upper
        // value never stands for a tick: 21 and 1 give a 20 tick period
        if (ring_mode && count_inc == upper_limit)
          count_next = lower_limit;
        else if (count_reg == upper_limit)
          count_next = ring_mode ? lower_limit : count_reg;
        else
          count_next = count_inc;
      end
    end
  end

  // state update; frozen while disabled, except match clears
  always @(posedge sys_clk) begin
    if (!nrst) begin
      count_reg         <= {W{1'b0}};
      capture_reg       <= {W{1'b0}};
      capture_valid_reg <= 1'b0;
      running_reg       <= 1'b0;
      match_reg         <= 1'b0;
    end else if (active) begin
      count_reg   <= count_next;
      running_reg <= running_next;
      // capture uses the pre-stop value so the width is not lost
      if (capture_evt) begin
        capture_reg       <= count_reg;
        capture_valid_reg <= 1'b1;
      end
      // one-clock strobe on the count becoming equal to compare a
      match_reg <= (count_next == compare_a) &&
                   (count_next != count_reg || (running_reg && tick &&
                    !stop_evt && ring_mode));
    end else if (clk_en) begin
      match_reg <= 1'b0;
    end
  end
endmodule // pwl_counter

//--- verif/pwl_props.sv
// pwl_props.sv: port checker for pwl_top
// assumes it is bound onto pwl_top, one clock domain on sys_clk
module pwl_props #(
  parameter CAP_ADDR = 16'h03e8
) (
  input wire        sys_clk,
  input wire        nrst,
  input wire        clk_en,
  input wire        meas_in,
  input wire        meas_enable,
  input wire        meas_low_time,
  input wire [15:0] buf_addr,
  input wire [31:0] buf_rdata,
  input wire [31:0] meas_count,
  input wire [31:0] meas_capture,
  input wire        meas_running,
  input wire        log_strobe,
  input wire        log_running,
  input wire [31:0] log_points,
  input wire        log_done
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // width channel: edges start, stop and capture
  rise_start_a: assert property (meas_enable && clk_en
    && !meas_low_time && $rose(meas_in) |=> meas_running)
    else $error("no start on rise");
  low_swap_a: assert property (meas_enable && clk_en
    && meas_low_time && $fell(meas_in) |=> meas_running)
    else $error("no start on fall");
  stop_cap_a: assert property (meas_enable && clk_en
    && !meas_low_time && $fell(meas_in) |=> !meas_running
    && meas_count == 32'h0 && meas_capture == $past(meas_count))
    else $error("stop or capture wrong");
  count_step_a: assert property (meas_running && meas_enable
    && clk_en && $stable(meas_in)
    |=> meas_count == $past(meas_count) + 32'h1)
    else $error("count did not step");
  hold_off_a: assert property (!meas_enable |=> $stable(meas_count))
    else $error("count moved while disabled");
  // read port is registered, one clock behind the address
  read_cap_a: assert property (clk_en && buf_addr == CAP_ADDR
    |=> buf_rdata == $past(meas_capture))
    else $error("read data wrong");
  // logging channel
  strobe_one_a: assert property (log_strobe |=> !log_strobe)
    else $error("strobe wider than a clock");
  points_step_a: assert property (log_strobe && clk_en
    |=> log_points == $past(log_points) + 32'h1)
    else $error("points did not step");
  done_stop_a: assert property ($rose(log_done)
    |-> ##[0:3] !log_running)
    else $error("ring kept running");
endmodule // pwl_props

bind pwl_top pwl_props #(.CAP_ADDR(CAP_ADDR)) u_pwl_props (.*);

//--- verif/pwl_field.sv
// pwl_field.sv: field input source and a/d sampler beside pwl_top
// assumes the bench clock; the input moves 1 ns after a rising edge
module pwl_field (
  input  wire  sys_clk,
  input  wire  log_strobe,
  output logic meas_in,
  output int   samples,
  output int   gap
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cyc = 0;
  int   last = 0;
  logic strobe_q = 1'b0;
  initial meas_in = 1'b0;
  initial samples = 0;
  // acquire on each strobe rise, noting clocks since the previous one
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    strobe_q <= log_strobe;
    if (log_strobe && !strobe_q) begin
      samples <= samples + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end
  // level held by the caller until the next call
  task go(input logic lvl);
    @(posedge sys_clk);
    #1 meas_in = lvl;
  endtask
endmodule // pwl_field

//--- verif/testbench.sv
// testbench.sv: self-checking bench for pwl_top
// assumes pwl_field drives the field input and samples the strobe
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        clk_en = 1'b1;
  logic        meas_enable = 1'b1;
  logic        meas_low_time = 1'b0;
  logic        meas_ring_mode = 1'b0;
  logic        log_start_in = 1'b0;
  logic        log_enable = 1'b1;
  logic [15:0] buf_addr = 16'h0000;
  logic [31:0] buf_rdata, meas_count, meas_capture, log_points, exp_cap;
  logic        meas_in, meas_capture_valid, meas_running;
  logic        log_strobe, log_running, log_done;
  int          miscompares = 0, compares = 0, samples, gap, w, base;
  // five points keep the logging run short
  pwl_top #(.LOG_POINTS(32'h5)) u_pwl_top (.*);
  pwl_field u_pwl_field (.*);
  initial forever #50 sys_clk = ~sys_clk;
  task check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // pulse of w clocks; counting starts the clock after the edge
  task pulse(input logic lvl, input int n);
    u_pwl_field.go(lvl);
    repeat (n - 1) @(posedge sys_clk);
    u_pwl_field.go(!lvl);
  endtask
  task end_sim;
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h9ab1cdf1));
    exp_cap = 32'h0;
    step(10);
    nrst = 1'b1;
    meas_ring_mode = 1'($urandom_range(1, 0));
    // high time first, then low time; some pulses with counting off
    for (int k = 0; k < 8; k++) begin
      if (k == 4) begin
        meas_low_time = 1'b1;
        u_pwl_field.go(1'b1);
      end
      meas_enable = (k % 4 != 2);
      w = $urandom_range(40, 2);
      pulse(!meas_low_time, w);
      if (meas_enable)
        exp_cap = w - 1;
      step(2);
      check("capture", meas_capture, exp_cap);
      buf_addr = k[0] ? 16'h03e8 : 16'($urandom_range(999, 0));
      step(2);
      check("rdata", buf_rdata, k[0] ? exp_cap : 32'h0);
    end
    check("valid", meas_capture_valid, 32'h1);
    // a short freeze must not disturb anything
    clk_en = 1'b0;
    step(4);
    clk_en = 1'b1;
    check("count", meas_count, 32'h0);
    // logging run: start pulse, strobes, stop after the set points
    base = samples;
    log_start_in = 1'b1;
    step(1);
    log_start_in = 1'b0;
    for (int i = 0; i < 3000 && log_done !== 1'b1; i++)
      step(1);
    step(4);
    check("done", log_done, 32'h1);
    check("points", log_points, 32'h5);
    check("samples", samples - base, 5);
    // 20 ring steps of 10 clocks between acquisitions
    check("gap", gap, 200);
    check("running", log_running, 32'h0);
    end_sim;
  end
endmodule // testbench
